// ---- src/flash_cmd_params.svh ----
/*
 Constants of the serial flash command engine: op-codes, frame lengths,
 status bit positions, reset values, protection bounds and clock figures.
 Assumes a 64 KByte array addressed by 16 bits.
*/
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// ----------------------------------------------------------------
// Op-codes
// ----------------------------------------------------------------
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_ARM 8'h50
`define OP_STATUS_WRITE 8'h01
`define OP_READ 8'h03
`define OP_PROGRAM 8'h02
`define OP_AUTO_INC 8'hAF
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'h52
`define OP_CHIP_ERASE 8'h60
`define OP_ID_A 8'h90
`define OP_ID_B 8'hAB

// ----------------------------------------------------------------
// Frame lengths in whole bytes
// ----------------------------------------------------------------
`define BYTES_OP 3'h1
`define BYTES_OP_DATA 3'h2
`define BYTES_OP_ADDR 3'h4
`define BYTES_OP_ADDR_DATA 3'h5
`define BYTES_SATURATE 3'h7

// ----------------------------------------------------------------
// Status byte layout and reset values
// ----------------------------------------------------------------
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP0 2
`define ST_BP1 3
`define ST_AUTO 6
`define ST_LOCK 7
`define BP_RESET 2'h3

// ----------------------------------------------------------------
// Array geometry and protection
// ----------------------------------------------------------------
`define TOP_ADDR 16'hFFFF
`define SECTOR_SPAN 16'h0FFF
`define BLOCK_SPAN 16'h7FFF
`define PROT_QUARTER_BASE 16'hC000
`define PROT_HALF_BASE 16'h8000
`define ERASED_BYTE 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_PERIOD_NS 40
`define BYTE_PROGRAM_TIME_NS 1000

`endif

// ---- src/flash_cmd_pkg.sv ----
/*
 Types of the serial flash command engine.
 Assumes flash_cmd_params.svh for all numeric constants.
*/
package flash_cmd_pkg;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_ERASE = 2'b01,
		ENG_PROGRAM = 2'b10
	} engine_state_t;

	typedef enum logic [1:0] {
		OUT_NONE = 2'b00,
		OUT_ARRAY = 2'b01,
		OUT_STATUS = 2'b10,
		OUT_ID = 2'b11
	} out_mode_t;

endpackage

// ---- src/flash_array_mem.sv ----
/*
 Flash array storage: one write port on the core clock, one registered
 read port on the serial clock.
 Assumes writes and reads of one cell never coincide in useful traffic.
*/
`timescale 1ns/1ns
module flash_array_mem #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 8
) (
	input wire logic wrClk,
	input wire logic write_enable_cmd,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic rdClk,
	input wire logic rdEn,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);

	logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

	always_ff @(posedge wrClk)
	begin
		if (write_enable_cmd)
		begin
			cells[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge rdClk)
	begin
		if (rdEn)
		begin
			rdData <= cells[rdAddr];
		end
	end

endmodule // flash_array_mem

// ---- src/serial_flash_command_engine.sv ----
/*
 Command decoder and sequencer of a serial NOR flash, 64 KByte array.
 Assumes SPI mode 0 or 3, sck quiet while selectN is high, and selectN
 high for at least three ref_clk periods between frames.
*/
//
// Function
// - Op-code, address and data bus cycles are each exactly eight clocks.
// - Address bit 15 is the top decoded bit; higher bits ignored.
// - Op 20H erases the 4 KByte sector given by address bits 15..12.
// - Op 52H erases the 32 KByte block given by address bit 15.
// - Op 60H erases everything unless any area is protected.
// - Program and erase commands aimed at protected areas are ignored, except 52H, which level 1 never blocks.
// - Write-enable sets the write latch flag.
// - Op 04H clears the write latch and auto-increment flags.
// - Op 03H plus address streams bytes, address incrementing each byte.
// - Read address wraps from the top address to zero.
// - Op 02H plus address and data programs one byte, busy meanwhile.
// - Program and erase start on deselect after the last bit.
// - Op AFH with address and data enters auto-increment and programs.
// - In auto-increment, AFH plus data programs the next address.
// - Auto-increment stops at top unprotected address, clearing mode and latch.
// - Status read works anytime and repeats until deselect.
// - Status write acts only directly after the arm command.
// - Identification returns maker or device code by address bit 0, alternating.
// - Inputs sampled on rising sck, MSB first, frame starts on select fall.
// - Select rising mid byte aborts the instruction.
// - Status bit 0 busy, bit 1 write latch, bit 6 auto-increment.
//
`timescale 1ns/1ns
`include "flash_cmd_params.svh"
module serial_flash_command_engine #(
	parameter int ADDR_W = 16,
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
	parameter int BYTE_PROGRAM_TIME_NS = `BYTE_PROGRAM_TIME_NS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic selectN,
	input wire logic mosi,
	output logic miso,
	output logic misoOe,
	output logic busy,
	output logic writeLatch,
	output logic autoInc,
	output logic [1:0] protectLevel
);

	localparam int PROG_RAW = (BYTE_PROGRAM_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS;
	localparam int PROG_CYCLES = (PROG_RAW < 1) ? 1 : PROG_RAW;
	localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

	// ----------------------------------------------------------------
	// Link side, clocked by sck
	// ----------------------------------------------------------------
	logic frameFresh;
	logic [2:0] bitPhase_q;
	logic [2:0] byteNum_q;
	logic [39:0] shiftIn_q;
	logic [7:0] opLink_q;
	logic [ADDR_W-1:0] rdPtr_q;
	logic idSel_q;
	logic [7:0] idByte_q;
	logic [7:0] stSync1_q;
	logic [7:0] stSync2_q;
	logic [7:0] statusLink_q;
	flash_cmd_pkg::out_mode_t outMode_q;
	logic pendLoad_q;
	logic [7:0] misoSr_q;
	logic oeLink_q;
	logic [2:0] phaseNow;
	logic [2:0] byteNow;
	logic [39:0] wordIn;
	logic [7:0] opNow;
	logic byteDone;
	logic loadArray;
	logic loadStatus;
	logic loadId;
	logic memRdEn;
	logic [ADDR_W-1:0] memRdAddr;
	logic [7:0] memRdData;
	logic [7:0] byteSel;
	logic [7:0] statusByte;

	// Async set by deselect; every frame restarts its counts here
	always_ff @(posedge sck or posedge selectN)
	begin
		if (selectN)
			frameFresh <= 1'b1;
		else
			frameFresh <= 1'b0;
	end

	always_comb
	begin
		phaseNow = frameFresh ? 3'h1 : bitPhase_q + 3'h1;
		byteNow = byteNum_q;
		if (frameFresh)
			byteNow = 3'h0;
		else if (bitPhase_q == 3'h7 && byteNum_q != `BYTES_SATURATE)
			byteNow = byteNum_q + 3'h1;
		wordIn = {shiftIn_q[38:0], mosi};
		byteDone = (phaseNow == 3'h0);
		opNow = (byteNow == `BYTES_OP) ? wordIn[7:0] : opLink_q;
		loadStatus = byteDone && byteNow >= `BYTES_OP && opNow == `OP_STATUS_READ;
		loadArray = byteDone && byteNow >= `BYTES_OP_ADDR && opLink_q == `OP_READ;
		loadId = byteDone && byteNow >= `BYTES_OP_ADDR
			&& (opLink_q == `OP_ID_A || opLink_q == `OP_ID_B);
		memRdEn = loadArray;
		memRdAddr = (byteNow == `BYTES_OP_ADDR) ? wordIn[ADDR_W-1:0] : rdPtr_q;
	end

	// Bit and byte counting, eight clocks to a bus cycle
	always_ff @(posedge sck)
	begin
		bitPhase_q <= phaseNow;
		byteNum_q <= byteNow;
		shiftIn_q <= wordIn;
	end

	always_ff @(posedge sck)
	begin
		if (byteDone && byteNow == `BYTES_OP)
			opLink_q <= wordIn[7:0];
	end

	// Pointer width makes the wrap from the top address to zero
	always_ff @(posedge sck)
	begin
		if (loadArray)
			rdPtr_q <= memRdAddr + 16'h0001;
	end

	always_ff @(posedge sck)
	begin
		if (loadId)
		begin
			idSel_q <= (byteNow == `BYTES_OP_ADDR) ? ~wordIn[0] : ~idSel_q;
			if ((byteNow == `BYTES_OP_ADDR) ? wordIn[0] : idSel_q)
				idByte_q <= PART_CODE;
			else
				idByte_q <= MAKER_CODE;
		end
	end

	// Status byte crossing; settles during the op-code byte
	always_ff @(posedge sck)
	begin
		stSync1_q <= statusByte;
		stSync2_q <= stSync1_q;
	end

	always_ff @(posedge sck)
	begin
		if (loadStatus)
			statusLink_q <= stSync2_q;
	end

	always_ff @(posedge sck)
	begin
		if (loadStatus)
			outMode_q <= flash_cmd_pkg::OUT_STATUS;
		else if (loadArray)
			outMode_q <= flash_cmd_pkg::OUT_ARRAY;
		else if (loadId)
			outMode_q <= flash_cmd_pkg::OUT_ID;
	end

	always_ff @(posedge sck or posedge selectN)
	begin
		if (selectN)
			pendLoad_q <= 1'b0;
		else
			pendLoad_q <= loadStatus || loadArray || loadId;
	end

	always_comb
	begin
		case (outMode_q)
			flash_cmd_pkg::OUT_ARRAY: byteSel = memRdData;
			flash_cmd_pkg::OUT_STATUS: byteSel = statusLink_q;
			flash_cmd_pkg::OUT_ID: byteSel = idByte_q;
			default: byteSel = `ERASED_BYTE;
		endcase
	end

	// Output shifts on the falling edge, half a clock ahead of sampling
	always_ff @(negedge sck)
	begin
		if (pendLoad_q)
			misoSr_q <= byteSel;
		else
			misoSr_q <= {misoSr_q[6:0], 1'b1};
	end

	always_ff @(negedge sck or posedge selectN)
	begin
		if (selectN)
			oeLink_q <= 1'b0;
		else if (pendLoad_q)
			oeLink_q <= 1'b1;
	end

	assign miso = misoSr_q[7];
	assign misoOe = oeLink_q;

	// ----------------------------------------------------------------
	// Core side, clocked by ref_clk
	// ----------------------------------------------------------------
	logic selSync1_q;
	logic selSync2_q;
	logic selPrev_q;
	logic frameEnd;
	logic complete;
	logic [7:0] cmdOp;
	logic [ADDR_W-1:0] cmdAddr;
	logic [7:0] cmdData;
	logic cmdWren;
	logic cmdWrdi;
	logic cmdArm;
	logic cmdStatusWrite;
	logic mayWrite;
	logic startSector;
	logic startBlock;
	logic startChip;
	logic startProgram;
	logic startAutoFirst;
	logic startAutoNext;
	logic progDone;
	logic autoExit;
	logic [ADDR_W-1:0] lastFree;
	logic writeLatch_q;
	logic autoInc_q;
	logic armed_q;
	logic [1:0] bp_q;
	logic lock_q;
	flash_cmd_pkg::engine_state_t state_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [ADDR_W-1:0] endPtr_q;
	logic [ADDR_W-1:0] autoAddr_q;
	logic [7:0] wrData_q;
	logic [15:0] waitCnt_q;
	logic memWe;
	logic [7:0] memWrData;

	// Protected when at or above the base set by the level; block ops are never protected at level 1
	function automatic logic isProtected(input logic [ADDR_W-1:0] addr, input logic [1:0] bp,
		input logic blockOp);
		case (bp)
			2'h0: isProtected = 1'b0;
			2'h1: isProtected = !blockOp && addr >= `PROT_QUARTER_BASE;
			2'h2: isProtected = addr >= `PROT_HALF_BASE;
			default: isProtected = 1'b1;
		endcase
	endfunction

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			selSync1_q <= 1'b1;
			selSync2_q <= 1'b1;
			selPrev_q <= 1'b1;
		end
		else
		begin
			selSync1_q <= selectN;
			selSync2_q <= selSync1_q;
			selPrev_q <= selSync2_q;
		end
	end

	// Link registers are still while deselected, so they are read here
	always_comb
	begin
		frameEnd = selSync2_q && !selPrev_q;
		complete = (bitPhase_q == 3'h0);
		cmdOp = shiftIn_q[7:0];
		cmdAddr = shiftIn_q[ADDR_W-1:0];
		cmdData = shiftIn_q[7:0];
		case (byteNum_q)
			`BYTES_OP_DATA: cmdOp = shiftIn_q[15:8];
			`BYTES_OP_ADDR: cmdOp = shiftIn_q[31:24];
			`BYTES_OP_ADDR_DATA:
			begin
				cmdOp = shiftIn_q[39:32];
				cmdAddr = shiftIn_q[ADDR_W+7:8];
			end
			default: cmdOp = shiftIn_q[7:0];
		endcase
		case (bp_q)
			2'h0: lastFree = `TOP_ADDR;
			2'h1: lastFree = `PROT_QUARTER_BASE - 16'h0001;
			default: lastFree = `PROT_HALF_BASE - 16'h0001;
		endcase
	end

	function automatic logic isCmd(input logic [2:0] bytes, input logic [7:0] op,
		input logic [2:0] wantBytes, input logic [7:0] wantOp);
		isCmd = bytes == wantBytes && op == wantOp;
	endfunction

	always_comb
	begin
		mayWrite = frameEnd && complete && writeLatch_q && state_q == flash_cmd_pkg::ENG_IDLE;
		cmdWren = frameEnd && complete && isCmd(byteNum_q, cmdOp, `BYTES_OP, `OP_WRITE_ENABLE);
		cmdWrdi = frameEnd && complete && isCmd(byteNum_q, cmdOp, `BYTES_OP, `OP_WRITE_DISABLE);
		cmdArm = frameEnd && complete && isCmd(byteNum_q, cmdOp, `BYTES_OP, `OP_STATUS_ARM);
		cmdStatusWrite = frameEnd && complete
			&& isCmd(byteNum_q, cmdOp, `BYTES_OP_DATA, `OP_STATUS_WRITE);
		startChip = mayWrite && isCmd(byteNum_q, cmdOp, `BYTES_OP, `OP_CHIP_ERASE)
			&& bp_q == 2'h0;
		startSector = mayWrite && isCmd(byteNum_q, cmdOp, `BYTES_OP_ADDR, `OP_SECTOR_ERASE)
			&& !isProtected(cmdAddr & ~`SECTOR_SPAN, bp_q, 1'b0);
		startBlock = mayWrite && isCmd(byteNum_q, cmdOp, `BYTES_OP_ADDR, `OP_BLOCK_ERASE)
			&& !isProtected(cmdAddr & ~`BLOCK_SPAN, bp_q, 1'b1);
		startProgram = mayWrite && !autoInc_q
			&& isCmd(byteNum_q, cmdOp, `BYTES_OP_ADDR_DATA, `OP_PROGRAM)
			&& !isProtected(cmdAddr, bp_q, 1'b0);
		startAutoFirst = mayWrite && !autoInc_q
			&& isCmd(byteNum_q, cmdOp, `BYTES_OP_ADDR_DATA, `OP_AUTO_INC)
			&& !isProtected(cmdAddr, bp_q, 1'b0);
		startAutoNext = mayWrite && autoInc_q
			&& isCmd(byteNum_q, cmdOp, `BYTES_OP_DATA, `OP_AUTO_INC);
		progDone = state_q == flash_cmd_pkg::ENG_PROGRAM && waitCnt_q == PROG_LAST;
		autoExit = progDone && autoInc_q && ptr_q == lastFree;
	end

	// Write latch: the write-enable set wins over any clear
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			writeLatch_q <= 1'b0;
		else if (cmdWren)
			writeLatch_q <= 1'b1;
		else if (cmdWrdi || autoExit)
			writeLatch_q <= 1'b0;
		else if (startSector || startBlock || startChip || startProgram)
			writeLatch_q <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			autoInc_q <= 1'b0;
		else if (startAutoFirst)
			autoInc_q <= 1'b1;
		else if (cmdWrdi || autoExit)
			autoInc_q <= 1'b0;
	end

	// Any completed or aborted frame other than a completed arm command disarms the status write
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			armed_q <= 1'b0;
		else if (frameEnd)
			armed_q <= cmdArm;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			bp_q <= `BP_RESET;
			lock_q <= 1'b0;
		end
		else if (cmdStatusWrite && armed_q)
		begin
			bp_q <= {cmdData[`ST_BP1], cmdData[`ST_BP0]};
			lock_q <= cmdData[`ST_LOCK];
		end
	end

	// Erase runs one byte per clock; a byte program waits out its time
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_q <= flash_cmd_pkg::ENG_IDLE;
			ptr_q <= '0;
			endPtr_q <= '0;
			wrData_q <= `ERASED_BYTE;
			waitCnt_q <= 16'h0000;
			autoAddr_q <= '0;
		end
		else
		begin
			case (state_q)
				flash_cmd_pkg::ENG_IDLE:
				begin
					waitCnt_q <= 16'h0000;
					if (startChip)
					begin
						state_q <= flash_cmd_pkg::ENG_ERASE;
						ptr_q <= '0;
						endPtr_q <= `TOP_ADDR;
					end
					else if (startSector)
					begin
						state_q <= flash_cmd_pkg::ENG_ERASE;
						ptr_q <= cmdAddr & ~`SECTOR_SPAN;
						endPtr_q <= cmdAddr | `SECTOR_SPAN;
					end
					else if (startBlock)
					begin
						state_q <= flash_cmd_pkg::ENG_ERASE;
						ptr_q <= cmdAddr & ~`BLOCK_SPAN;
						endPtr_q <= cmdAddr | `BLOCK_SPAN;
					end
					else if (startProgram || startAutoFirst || startAutoNext)
					begin
						state_q <= flash_cmd_pkg::ENG_PROGRAM;
						ptr_q <= startAutoNext ? autoAddr_q : cmdAddr;
						autoAddr_q <= (startAutoNext ? autoAddr_q : cmdAddr) + 16'h0001;
						wrData_q <= cmdData;
					end
				end
				flash_cmd_pkg::ENG_ERASE:
				begin
					if (ptr_q == endPtr_q)
						state_q <= flash_cmd_pkg::ENG_IDLE;
					else
						ptr_q <= ptr_q + 16'h0001;
				end
				flash_cmd_pkg::ENG_PROGRAM:
				begin
					waitCnt_q <= waitCnt_q + 16'h0001;
					if (progDone)
						state_q <= flash_cmd_pkg::ENG_IDLE;
				end
				default: state_q <= flash_cmd_pkg::ENG_IDLE;
			endcase
		end
	end

	assign memWe = state_q == flash_cmd_pkg::ENG_ERASE
		|| (state_q == flash_cmd_pkg::ENG_PROGRAM && waitCnt_q == 16'h0000);
	assign memWrData = (state_q == flash_cmd_pkg::ENG_ERASE) ? `ERASED_BYTE : wrData_q;

	flash_array_mem #(
		.ADDR_W(ADDR_W),
		.DATA_W(8)
	) arrayMem (
		.wrClk(ref_clk),
		.write_enable_cmd(memWe),
		.wrAddr(ptr_q),
		.wrData(memWrData),
		.rdClk(sck),
		.rdEn(memRdEn),
		.rdAddr(memRdAddr),
		.rdData(memRdData)
	);

	always_comb
	begin
		statusByte = 8'h00;
		statusByte[`ST_BUSY] = busy;
		statusByte[`ST_WEL] = writeLatch_q;
		statusByte[`ST_BP0] = bp_q[0];
		statusByte[`ST_BP1] = bp_q[1];
		statusByte[`ST_AUTO] = autoInc_q;
		statusByte[`ST_LOCK] = lock_q;
	end

	assign busy = state_q != flash_cmd_pkg::ENG_IDLE;
	assign writeLatch = writeLatch_q;
	assign autoInc = autoInc_q;
	assign protectLevel = bp_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_prog_req;
		startProgram;
	endsequence
	sequence s_prog_write(logic [ADDR_W-1:0] a);
		busy && memWe && ptr_q == a ##1 busy && !memWe;
	endsequence

	a_write_enable_cmd_sets_latch: assert property (cmdWren |=> writeLatch_q)
		else $error("write enable did not set latch");
	a_write_disable_cmd_clears_flags: assert property (cmdWrdi |=> !writeLatch_q && !autoInc_q)
		else $error("write disable left flags set");
	a_write_needs_latch: assert property ($rose(busy) |-> $past(writeLatch_q))
		else $error("write started without latch");
	a_chip_prot_ignored: assert property (frameEnd && complete && byteNum_q == `BYTES_OP
		&& cmdOp == `OP_CHIP_ERASE && bp_q != 2'h0 && !busy |=> !busy)
		else $error("chip erase ran while protected");
	a_sector_span: assert property (startSector |=> ptr_q[11:0] == 12'h000
		&& endPtr_q[11:0] == 12'hFFF && endPtr_q[15:12] == ptr_q[15:12])
		else $error("sector erase span wrong");
	a_block_span: assert property (startBlock |=> ptr_q[14:0] == 15'h0000
		&& endPtr_q[14:0] == 15'h7FFF)
		else $error("block erase span wrong");
	a_prog_sequence: assert property (s_prog_req |=> s_prog_write($past(cmdAddr)))
		else $error("byte program did not write once at its address");
	a_abort_partial: assert property (frameEnd && !complete && !busy
		|=> !busy && writeLatch_q == $past(writeLatch_q))
		else $error("partial frame was executed");
	a_arm_required: assert property (cmdStatusWrite && !armed_q |=> $stable(bp_q))
		else $error("status write took effect unarmed");
	a_auto_exit: assert property (autoExit |=> !autoInc_q && !writeLatch_q)
		else $error("auto increment did not stop at top");

endmodule // serial_flash_command_engine

// ---- testbench/spi_host_model.sv ----
/*
 Host SPI controller model, mode 0, facing the flash command engine.
 Assumes the engine samples mosi on rising sck and shifts miso on falling sck.
*/
`timescale 1ns/1ns
module spi_host_model (
	output logic sck,
	output logic selectN,
	output logic mosi,
	input wire logic miso,
	input wire logic misoOe
);
	// Link clock of 160 ns, still between frames
	localparam int HALF = 80;
	initial
	begin
		sck = 1'b0;
		selectN = 1'b1;
		mosi = 1'b1;
	end
	task automatic frame(input logic [39:0] tx, input int nBits, input int nRd,
		output logic [23:0] rx, output logic oeSeen);
		rx = 24'h0;
		oeSeen = 1'b1;
		#13 selectN = 1'b0;
		#HALF;
		for (int i = 0; i < nBits + nRd * 8; i++)
		begin
			// Dummy bits toggle so no stale level looks meaningful
			mosi = (i < nBits) ? tx[39 - i] : ~mosi;
			#HALF sck = 1'b1;
			if (i >= nBits)
			begin
				rx = {rx[22:0], miso};
				oeSeen = oeSeen & misoOe;
			end
			#HALF sck = 1'b0;
		end
		#HALF selectN = 1'b1;
		mosi = ~mosi;
		#200;
	endtask
endmodule // spi_host_model

// ---- testbench/tb.sv ----
/*
 Self-checking bench of the flash command engine with a byte-array model.
 Assumes spi_host_model as the host and the engine's default timing.
*/
`timescale 1ns/1ns
module tb;
	logic refClk, rst, sck, selectN, mosi, miso, misoOe, busy, writeLatch, autoInc, oe;
	logic [1:0] protectLevel;
	logic [23:0] rx;
	logic [7:0] mem [0:65535];
	int errTotal, checksDone, write_latch_flag, auto, lvl, nextA;
	localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
	localparam logic [7:0] PART = 8'hC3; // arbitrary value

	initial
	begin
		refClk = 1'b0;
		forever #20 refClk = ~refClk;
	end

	serial_flash_command_engine #(.MAKER_CODE(MAKER), .PART_CODE(PART))
	u_serial_flash_command_engine (.ref_clk(refClk), .rst(rst), .sck(sck),
		.selectN(selectN), .mosi(mosi), .miso(miso), .misoOe(misoOe), .busy(busy),
		.writeLatch(writeLatch), .autoInc(autoInc), .protectLevel(protectLevel));
	spi_host_model u_spi_host_model (.sck(sck), .selectN(selectN), .mosi(mosi),
		.miso(miso), .misoOe(misoOe));

	// ----------------------------------------------------------------
	// Checking and host tasks
	// ----------------------------------------------------------------
	task automatic completeRun();
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checksDone++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic cmpFlags();
		cmpByte({5'h0, autoInc, writeLatch, busy}, {5'h0, auto[0], write_latch_flag[0], 1'b0}, "flags");
	endtask
	task automatic xfer(input logic [39:0] tx, input int nBits, input int nRd);
		@(negedge refClk);
		u_spi_host_model.frame(tx, nBits, nRd, rx, oe);
		if (nRd > 0)
			cmpByte({7'h0, oe}, 8'h01, "drive");
	endtask
	task automatic rdStatus(input logic b);
		xfer({8'h05, 32'h0}, 8, 2);
		cmpByte(rx[15:8], {1'b0, auto[0], 2'h0, lvl[1:0], write_latch_flag[0], b}, "status");
		cmpByte(rx[7:0], {1'b0, auto[0], 2'h0, lvl[1:0], write_latch_flag[0], b}, "status");
	endtask
	task automatic settle(input logic go);
		repeat (8) @(negedge refClk);
		cmpByte({7'h0, busy}, {7'h0, go}, "busy");
		for (int i = 0; busy !== 1'b0; i++)
		begin
			if (i > 40000)
			begin
				errTotal++;
				$display("[FAIL] %0t busy stuck", $time);
				completeRun();
			end
			@(negedge refClk);
		end
		cmpFlags();
	endtask
	task automatic simple(input logic [7:0] op, input int nBits);
		xfer({op, 32'h0}, nBits, 0);
		// Only whole op-code frames move the flags
		if (nBits == 8 && op == 8'h06)
			write_latch_flag = 1;
		if (nBits == 8 && op == 8'h04)
		begin
			write_latch_flag = 0;
			auto = 0;
		end
		settle(1'b0);
	endtask
	task automatic readChk(input int a, input int n);
		xfer({8'h03, 8'($urandom), a[15:0], 8'h0}, 32, n);
		for (int i = 0; i < n; i++)
			cmpByte(rx[8 * (n - 1 - i) +: 8], mem[(a + i) & 32'hFFFF], "read");
	endtask
	task automatic setLvl(input int l);
		xfer({8'h50, 32'h0}, 8, 0);
		xfer({8'h01, 4'h0, l[1:0], 2'h0, 24'h0}, 16, 0);
		lvl = l;
		repeat (6) @(negedge refClk);
		cmpByte({6'h0, protectLevel}, lvl[7:0], "level");
	endtask
	function automatic bit prot(input int a, input bit blk);
		return lvl == 3 || (lvl == 2 && a >= 32'h8000) || (lvl == 1 && !blk && a >= 32'hC000);
	endfunction
	// Kind: 0 program, 1 sector, 2 block, 3 chip, 4 auto entry, 5 auto next
	task automatic wr(input int kind, input int a, input logic [7:0] d);
		bit ok;
		logic [7:0] up;
		up = 8'($urandom);
		ok = write_latch_flag != 0 && !prot(a, kind == 2);
		case (kind)
			0: xfer({8'h02, up, a[15:0], d}, 40, 0);
			1: xfer({8'h20, up, a[15:0], 8'h0}, 32, 0);
			2: xfer({8'h52, up, a[15:0], 8'h0}, 32, 0);
			3: xfer({8'h60, 32'h0}, 8, 0);
			4: xfer({8'hAF, up, a[15:0], d}, 40, 0);
			default: xfer({8'hAF, d, 24'h0}, 16, 0);
		endcase
		if (kind == 0)
			ok = ok && auto == 0;
		if (kind == 3)
			ok = write_latch_flag != 0 && lvl == 0;
		if (kind == 5)
		begin
			ok = auto != 0;
			a = nextA;
		end
		if (ok)
		begin
			if (kind == 1)
				for (int i = a & 32'hF000; i <= (a & 32'hF000) + 32'hFFF; i++) mem[i] = 8'hFF;
			if (kind == 2)
				for (int i = a & 32'h8000; i <= (a & 32'h8000) + 32'h7FFF; i++) mem[i] = 8'hFF;
			if (kind == 3)
				for (int i = 0; i <= 32'hFFFF; i++) mem[i] = 8'hFF;
			if (kind == 0 || kind >= 4)
				mem[a & 32'hFFFF] = d;
			if (kind < 4)
				write_latch_flag = 0;
			if (kind == 4)
				auto = 1;
			nextA = a + 1;
			if (kind >= 4 && a == (lvl == 2 ? 32'h7FFF : lvl == 1 ? 32'hBFFF : 32'hFFFF))
			begin
				auto = 0;
				write_latch_flag = 0;
			end
			if (kind inside {[1:3]})
				rdStatus(1'b1);
		end
		settle(ok);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		errTotal = 0;
		checksDone = 0;
		void'($urandom(32'h8607));
		repeat (8) @(negedge refClk);
		rst = 1'b0;
		repeat (4) @(negedge refClk);
		write_latch_flag = 0;
		auto = 0;
		lvl = 3;
		rdStatus(1'b0);
		simple(8'h06, 8);
		write_latch_flag = 1;
		wr(3, 0, 8'h00);
		xfer({8'h01, 8'h00, 24'h0}, 16, 0);
		xfer({8'h50, 32'h0}, 8, 0);
		xfer({8'h05, 32'h0}, 8, 1);
		xfer({8'h01, 8'h00, 24'h0}, 16, 0);
		cmpByte({6'h0, protectLevel}, 8'h03, "unarmed");
		setLvl(0);
		write_latch_flag = 0;
		simple(8'h04, 8);
		simple(8'h06, 5);
		$display("test done: reset, arming, abort");
		simple(8'h06, 8);
		write_latch_flag = 1;
		wr(2, 32'($urandom) & 32'h7FFF, 8'h00);
		simple(8'h06, 8);
		write_latch_flag = 1;
		wr(1, 32'hFABC, 8'h00);
		wr(0, 32'h0123, 8'h5A);
		readChk(32'h0123, 1);
		for (int i = 0; i < 4; i++)
		begin
			simple(8'h06, 8);
			write_latch_flag = 1;
			wr(0, i == 0 ? 32'h0123 : i == 1 ? 32'h1123 : i == 2 ? 32'hFFFF : 0,
				8'($urandom));
		end
		readChk(32'hFFFF, 3);
		$display("test done: erase, program, wrap");
		simple(8'h06, 8);
		write_latch_flag = 1;
		wr(1, 32'h0FAB, 8'h00);
		readChk(32'h0123, 1);
		readChk(32'h1123, 1);
		setLvl(2);
		simple(8'h06, 8);
		write_latch_flag = 1;
		wr(0, 32'hF123, 8'($urandom));
		wr(3, 0, 8'h00);
		readChk(32'hF123, 1);
		wr(4, 32'h7FFE, 8'($urandom));
		wr(5, 0, 8'($urandom));
		readChk(32'h7FFE, 2);
		setLvl(0);
		simple(8'h06, 8);
		write_latch_flag = 1;
		wr(4, 32'h2000, 8'($urandom));
		wr(5, 0, 8'($urandom));
		write_latch_flag = 0;
		auto = 0;
		simple(8'h04, 8);
		readChk(32'h2000, 3);
		$display("test done: protection, auto increment");
		xfer({8'h90, 24'h1, 8'h0}, 32, 3);
		cmpByte(rx[23:16], PART, "id");
		cmpByte(rx[15:8], MAKER, "id");
		xfer({8'hAB, 32'h0}, 32, 3);
		cmpByte(rx[23:16], MAKER, "id");
		cmpByte(rx[7:0], MAKER, "id");
		$display("test done: identification");
		completeRun();
	end
endmodule // tb
